// *** design/xcs_pkg.sv ***
// constants, types and helpers shared by the switched call-setup block
// assumes one 250 MHz clock and a character-level line adapter around it
package xcs_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam longint unsigned CLK_HZ = 250_000_000;
	localparam longint unsigned T_SHORT_S = 2;
	localparam longint unsigned T_LONG_S = 60;
	localparam logic [35:0] TMO_SHORT_CYC = 36'(T_SHORT_S * CLK_HZ);
	localparam logic [35:0] TMO_LONG_CYC = 36'(T_LONG_S * CLK_HZ);
	localparam logic [4:0] ADP_RST_CYC = 5'h10;
	localparam int SYNC_COUNT = 2;

	// ************************************************************
	// IA5 characters seen or sent on the line
	// ************************************************************
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_SYNC = 8'h16;
	localparam logic [7:0] CH_BELL = 8'h07;
	localparam logic [7:0] CH_ZERO = 8'h30;

	// ************************************************************
	// completion codes: bit 7 marks an error, bit 6 intermediate
	// ************************************************************
	localparam logic [7:0] ST_NORMAL = 8'h00;
	localparam logic [7:0] ST_HALTED = 8'h01;
	localparam logic [7:0] ST_INFO = 8'h41;
	localparam logic [7:0] ST_BELL = 8'h42;
	localparam logic [7:0] ST_ERR_TMO = 8'h81;
	localparam logic [7:0] ST_ERR_RATE = 8'h82;

	// ************************************************************
	// requests and states
	// ************************************************************
	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_OPEN_OUT = 2'h1,
		OP_OPEN_IN = 2'h2,
		OP_HALT = 2'h3
	} xcs_op_t;

	typedef enum logic [11:0] {
		S_IDLE = 12'h001,
		S_RESET = 12'h002,
		S_READY = 12'h004,
		S_CALLREQ = 12'h008,
		S_SYNC = 12'h010,
		S_SEL = 12'h020,
		S_WAIT = 12'h040,
		S_IN_READY = 12'h080,
		S_BELL_HOLD = 12'h100,
		S_ACCEPT = 12'h200,
		S_DATA = 12'h400,
		S_CLEAR = 12'h800
	} xcs_state_t;

	// line rate in bit/s for a rate code, zero when unsupported
	function automatic logic [16:0] xcs_rate_bps(input logic [2:0] code);
		case (code)
			3'h0: xcs_rate_bps = 17'h00960;
			3'h1: xcs_rate_bps = 17'h012C0;
			3'h2: xcs_rate_bps = 17'h02580;
			3'h3: xcs_rate_bps = 17'h0BB80;
			3'h4: xcs_rate_bps = 17'h0FA00;
			default: xcs_rate_bps = 17'h00000;
		endcase
	endfunction : xcs_rate_bps

endpackage : xcs_pkg

// *** design/xcs_sel_mem.sv ***
// selection buffer: requester writes dial digits, call setup reads them
// assumes writer and reader never need the same word in one cycle
`timescale 1ns/100ps
module xcs_sel_mem #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 8
) (
	input wire logic mclk_i,
	input wire logic wr_i,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem_r [DEPTH];

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("selection buffer depth must be a power of two");
	end

	always_ff @(posedge mclk_i) begin
		if (wr_i) begin
			mem_r[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem_r[rd_addr_i];
	end
endmodule : xcs_sel_mem

// *** design/xcs_timer.sv ***
// supervision timer with a short and a long reload
// start wins over stop; expiry is a level held until the next start or stop
`timescale 1ns/100ps
module xcs_timer #(
	parameter logic [35:0] SHORT_CYC = 36'h0000000FF,
	parameter logic [35:0] LONG_CYC = 36'h000000FFF
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic long_i,
	input wire logic stop_i,
	output logic expired_o
);
	logic [35:0] cnt_r;
	logic run_r;

	if (SHORT_CYC == 36'h0 || LONG_CYC < SHORT_CYC) begin : g_chk
		$error("timer reloads must be nonzero and long >= short");
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 36'h0;
			run_r <= 1'b0;
			expired_o <= 1'b0;
		end else if (start_i) begin
			cnt_r <= (long_i ? LONG_CYC : SHORT_CYC) - 36'h1;
			run_r <= 1'b1;
			expired_o <= 1'b0;
		end else if (stop_i) begin
			run_r <= 1'b0;
			expired_o <= 1'b0;
		end else if (run_r) begin
			if (cnt_r == 36'h0) begin
				run_r <= 1'b0;
				expired_o <= 1'b1;
			end else begin
				cnt_r <= cnt_r - 36'h1;
			end
		end
	end
endmodule : xcs_timer

// *** design/xcs_call_setup.sv ***
// call establishment for a switched X.21 line, DTE side
// assumes a line adapter that moves whole IA5 characters and decodes DCE
// ready, ready-for-data and clear-confirm into levels
`timescale 1ns/100ps
module xcs_call_setup #(
	parameter int SEL_DEPTH = 32,
	parameter int CAP_DEPTH = 32,
	parameter logic [35:0] SHORT_CYC = xcs_pkg::TMO_SHORT_CYC,
	parameter logic [35:0] LONG_CYC = xcs_pkg::TMO_LONG_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire xcs_pkg::xcs_op_t req_op_i,
	input wire logic [2:0] req_rate_i,
	input wire logic [$clog2(SEL_DEPTH):0] req_sel_len_i,
	output logic req_ready_o,
	input wire logic resume_i,
	input wire logic sel_wr_i,
	input wire logic [$clog2(SEL_DEPTH)-1:0] sel_addr_i,
	input wire logic [7:0] sel_data_i,
	output logic stat_valid_o,
	output logic [7:0] stat_code_o,
	output logic cap_wr_o,
	output logic [$clog2(CAP_DEPTH)-1:0] cap_addr_o,
	output logic [7:0] cap_data_o,
	output logic adapter_rst_o,
	output logic adapter_en_o,
	output logic [16:0] line_rate_o,
	output logic ctrl_c_o,
	output logic clear_req_o,
	output logic tx_valid_o,
	output logic [7:0] tx_char_o,
	input wire logic tx_ready_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_char_i,
	input wire logic dce_ready_i,
	input wire logic rdy_data_i,
	input wire logic dce_clear_i,
	output logic data_phase_o,
	output logic frame_arm_o
);
	import xcs_pkg::*;

	localparam int SAW = $clog2(SEL_DEPTH);
	localparam int CAW = $clog2(CAP_DEPTH);

	if (CAP_DEPTH < 2 || (CAP_DEPTH & (CAP_DEPTH - 1)) != 0) begin : g_chk
		$error("capture depth must be a power of two");
	end

	xcs_state_t st_r;
	logic out_r;
	logic err_r;
	logic posted_r;
	logic gap_r;
	logic [4:0] rst_cnt_r;
	logic [SAW:0] len_r;
	logic [SAW:0] sel_idx_r;
	logic [1:0] sync_cnt_r;
	logic [CAW:0] cap_idx_r;
	logic [7:0] sel_rd_data;
	logic tmr_exp;

	// ************************************************************
	// event decode
	// ************************************************************
	logic is_open, rate_ok, open_take, rate_bad, halt_take;
	logic wait_st, timed_st, tx_acc, ev_plus, ev_bell, ev_rfd;
	logic ev_digit, ev_zero, ev_info, ev_tmo, ev_clr_done, sel_last;
	logic rst_done, tmr_start;

	assign is_open = req_op_i == OP_OPEN_OUT || req_op_i == OP_OPEN_IN;
	assign rate_ok = xcs_rate_bps(req_rate_i) != 17'h0;
	// an open is only seen while idle, a halt only while busy
	assign req_ready_o = is_open ? st_r == S_IDLE :
		(req_op_i == OP_HALT && st_r != S_IDLE);
	assign open_take = req_valid_i && req_ready_o && is_open && rate_ok;
	assign rate_bad = req_valid_i && req_ready_o && is_open && !rate_ok;
	assign halt_take = req_valid_i && req_ready_o &&
		req_op_i == OP_HALT && st_r != S_CLEAR;
	assign wait_st = st_r == S_WAIT || st_r == S_ACCEPT;
	assign timed_st = wait_st || st_r == S_READY || st_r == S_CALLREQ ||
		st_r == S_CLEAR;
	assign tx_acc = tx_valid_o && tx_ready_i;
	assign ev_plus = st_r == S_CALLREQ && rx_valid_i &&
		rx_char_i == CH_PLUS;
	assign ev_bell = st_r == S_IN_READY && rx_valid_i &&
		rx_char_i == CH_BELL;
	assign ev_rfd = wait_st && rdy_data_i;
	// only the first progress signal or identity reaches the buffer
	assign ev_digit = wait_st && rx_valid_i && !posted_r &&
		rx_char_i != CH_PLUS && rx_char_i != CH_SYNC &&
		cap_idx_r < (CAW + 1)'(CAP_DEPTH);
	assign ev_zero = ev_digit && cap_idx_r == '0 &&
		rx_char_i == CH_ZERO && st_r == S_WAIT;
	assign ev_info = wait_st && rx_valid_i && rx_char_i == CH_PLUS &&
		cap_idx_r != '0 && !posted_r;
	// ready-for-data beats a coincident expiry, else clear_req sticks in data
	assign ev_tmo = tmr_exp && timed_st && st_r != S_CLEAR && !ev_rfd;
	assign ev_clr_done = st_r == S_CLEAR && (dce_clear_i || tmr_exp);
	assign sel_last = tx_acc && sel_idx_r == len_r - (SAW + 1)'(1);
	assign rst_done = rst_cnt_r == ADP_RST_CYC - 5'h1;
	assign tmr_start = halt_take || ev_tmo || ev_zero ||
		(st_r == S_RESET && rst_done) ||
		(st_r == S_READY && dce_ready_i && out_r) ||
		(ev_plus && len_r == '0) ||
		(st_r == S_SEL && sel_last) ||
		(st_r == S_BELL_HOLD && resume_i);

	// ************************************************************
	// call state
	// ************************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= S_IDLE;
		end else if (halt_take) begin
			st_r <= S_CLEAR;
		end else begin
			case (st_r)
				S_IDLE: if (open_take) begin
					st_r <= S_RESET;
				end
				S_RESET: if (rst_done) begin
					st_r <= S_READY;
				end
				S_READY: if (ev_tmo) begin
					st_r <= S_CLEAR;
				end else if (dce_ready_i) begin
					st_r <= out_r ? S_CALLREQ : S_IN_READY;
				end
				S_CALLREQ: if (ev_tmo) begin
					st_r <= S_CLEAR;
				end else if (ev_plus) begin
					st_r <= len_r == '0 ? S_WAIT : S_SYNC;
				end
				S_SYNC: if (tx_acc && sync_cnt_r == 2'(SYNC_COUNT - 1)) begin
					st_r <= S_SEL;
				end
				S_SEL: if (sel_last) begin
					st_r <= S_WAIT;
				end
				S_IN_READY: if (ev_bell) begin
					st_r <= S_BELL_HOLD;
				end
				S_BELL_HOLD: if (resume_i) begin
					st_r <= S_ACCEPT;
				end
				S_WAIT, S_ACCEPT: if (ev_rfd) begin
					st_r <= S_DATA;
				end else if (ev_tmo) begin
					st_r <= S_CLEAR;
				end
				S_DATA: st_r <= S_DATA;
				S_CLEAR: if (ev_clr_done) begin
					st_r <= S_IDLE;
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// ************************************************************
	// per-call context
	// ************************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			out_r <= 1'b0;
			len_r <= '0;
			line_rate_o <= 17'h0;
			err_r <= 1'b0;
			rst_cnt_r <= 5'h0;
		end else begin
			if (open_take) begin
				out_r <= req_op_i == OP_OPEN_OUT;
				len_r <= req_op_i == OP_OPEN_OUT ? req_sel_len_i : '0;
				line_rate_o <= xcs_rate_bps(req_rate_i);
				err_r <= 1'b0;
			end else if (ev_tmo) begin
				err_r <= 1'b1;
			end
			rst_cnt_r <= st_r == S_RESET ? rst_cnt_r + 5'h1 : 5'h0;
		end
	end

	// ************************************************************
	// transmit side: syncs, then selection words
	// ************************************************************
	// gap_r skips one cycle after each accept so the memory read settles
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_valid_o <= 1'b0;
			tx_char_o <= 8'h00;
			gap_r <= 1'b0;
			sync_cnt_r <= 2'h0;
			sel_idx_r <= '0;
		end else begin
			gap_r <= tx_acc;
			if (tx_acc || halt_take) begin
				tx_valid_o <= 1'b0;
			end else if (!tx_valid_o && !gap_r && st_r == S_SYNC) begin
				tx_valid_o <= 1'b1;
				tx_char_o <= CH_SYNC;
			end else if (!tx_valid_o && !gap_r && st_r == S_SEL) begin
				tx_valid_o <= 1'b1;
				tx_char_o <= sel_rd_data;
			end
			if (st_r != S_SYNC) begin
				sync_cnt_r <= 2'h0;
			end else if (tx_acc) begin
				sync_cnt_r <= sync_cnt_r + 2'h1;
			end
			if (st_r != S_SEL) begin
				sel_idx_r <= '0;
			end else if (tx_acc) begin
				sel_idx_r <= sel_idx_r + (SAW + 1)'(1);
			end
		end
	end

	// ************************************************************
	// capture into the requester's buffer
	// ************************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_wr_o <= 1'b0;
			cap_addr_o <= '0;
			cap_data_o <= 8'h00;
			cap_idx_r <= '0;
			posted_r <= 1'b0;
		end else begin
			cap_wr_o <= ev_digit;
			if (ev_digit) begin
				cap_addr_o <= cap_idx_r[CAW-1:0];
				cap_data_o <= rx_char_i;
				cap_idx_r <= cap_idx_r + (CAW + 1)'(1);
			end else if (st_r == S_IDLE) begin
				cap_idx_r <= '0;
			end
			if (ev_info) begin
				posted_r <= 1'b1;
			end else if (st_r == S_IDLE) begin
				posted_r <= 1'b0;
			end
		end
	end

	// ************************************************************
	// completion status and line controls
	// ************************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			stat_valid_o <= 1'b0;
			stat_code_o <= ST_NORMAL;
			frame_arm_o <= 1'b0;
		end else begin
			stat_valid_o <= rate_bad || ev_clr_done || (!halt_take &&
				(ev_bell || ev_rfd || ev_info));
			frame_arm_o <= ev_rfd && !halt_take;
			if (rate_bad) begin
				stat_code_o <= ST_ERR_RATE;
			end else if (ev_clr_done) begin
				stat_code_o <= err_r ? ST_ERR_TMO : ST_HALTED;
			end else if (ev_bell) begin
				stat_code_o <= ST_BELL;
			end else if (ev_rfd) begin
				stat_code_o <= ST_NORMAL;
			end else if (ev_info) begin
				stat_code_o <= ST_INFO;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			adapter_rst_o <= 1'b0;
			adapter_en_o <= 1'b0;
			ctrl_c_o <= 1'b0;
			clear_req_o <= 1'b0;
			data_phase_o <= 1'b0;
		end else begin
			adapter_rst_o <= open_take || (st_r == S_RESET && !rst_done);
			adapter_en_o <= st_r != S_IDLE && !open_take &&
				!(st_r == S_RESET && !rst_done);
			// control lead on for call request, selection and acceptance
			ctrl_c_o <= !halt_take && !ev_clr_done && (ctrl_c_o ?
				st_r != S_CLEAR :
				(st_r == S_READY && dce_ready_i && out_r) ||
				(st_r == S_BELL_HOLD && resume_i));
			clear_req_o <= halt_take || ev_tmo ||
				(clear_req_o && !ev_clr_done);
			data_phase_o <= (ev_rfd || data_phase_o) && !halt_take;
		end
	end

	// ************************************************************
	// helpers
	// ************************************************************
	xcs_sel_mem #(.DEPTH(SEL_DEPTH), .WIDTH(8)) u_sel (
		.mclk_i(mclk_i),
		.wr_i(sel_wr_i),
		.wr_addr_i(sel_addr_i),
		.wr_data_i(sel_data_i),
		.rd_addr_i(sel_idx_r[SAW-1:0]),
		.rd_data_o(sel_rd_data)
	);

	xcs_timer #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_tmr (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.start_i(tmr_start),
		.long_i(ev_zero),
		.stop_i(!timed_st),
		.expired_o(tmr_exp)
	);

	// ************************************************************
	// checks
	// ************************************************************
	rate_refuse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		rate_bad |=> stat_valid_o && stat_code_o == ST_ERR_RATE && st_r == S_IDLE)
		else $error("bad rate not refused");
	reset_first_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		open_take |=> adapter_rst_o [*2] ##1 adapter_rst_o && !adapter_en_o)
		else $error("adapter not reset on open");
	call_req_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		st_r == S_READY && dce_ready_i && out_r && !halt_take && !ev_tmo
		|=> st_r == S_CALLREQ && ctrl_c_o)
		else $error("call request not entered");
	sync_first_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		tx_valid_o && st_r == S_SYNC && !$past(st_r == S_SEL)
		|-> tx_char_o == CH_SYNC)
		else $error("sync character expected");
	direct_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		ev_plus && !halt_take && !ev_tmo
		|=> st_r == (len_r == '0 ? S_WAIT : S_SYNC))
		else $error("plus handling wrong");
	capture_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		ev_digit |=> cap_wr_o && cap_data_o == $past(rx_char_i))
		else $error("progress character not captured");
	bell_status_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		ev_bell && !halt_take |=> stat_valid_o && stat_code_o == ST_BELL
		&& st_r == S_BELL_HOLD && !ctrl_c_o)
		else $error("bell status missing");
	accept_lead_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		st_r == S_BELL_HOLD && resume_i && !halt_take |=> ctrl_c_o)
		else $error("accept lead not raised");
	ready_data_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		ev_rfd && !halt_take |=> stat_code_o == ST_NORMAL && frame_arm_o
		&& data_phase_o ##1 !frame_arm_o)
		else $error("ready for data not completed");
	long_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		ev_zero && !halt_take |=> !tmr_exp [*8])
		else $error("long timeout not started");
	halt_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		halt_take |=> st_r == S_CLEAR && clear_req_o && !ctrl_c_o)
		else $error("halt did not clear");
	one_open_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		st_r != S_IDLE && is_open
		|-> !req_ready_o ##1 $stable(line_rate_o) && $stable(out_r))
		else $error("second open accepted");

endmodule : xcs_call_setup

// *** verif/xcs_dce_model.sv ***
// network terminating equipment model facing the call-setup block
// assumes the bench calls send_char and go_data on a quiet receive line
`timescale 1ns/100ps
module xcs_dce_model (
	input wire logic mclk_i,
	input wire logic adapter_en_i,
	input wire logic clear_req_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_char_i,
	output logic dce_ready_o,
	output logic rdy_data_o,
	output logic dce_clear_o,
	output logic rx_valid_o,
	output logic [7:0] rx_char_o,
	output logic tx_ready_o
);
	int tx_delay = 0;
	int tx_wait = 0;
	int clr_wait = 0;
	logic [7:0] tx_q[$];

	initial begin
		dce_ready_o = 1'b0;
		rdy_data_o = 1'b0;
		dce_clear_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_char_o = 8'hFF;
		tx_ready_o = 1'b0;
	end

	// ************************************************************
	// line behaviour
	// ************************************************************
	always @(negedge mclk_i) begin
		dce_ready_o <= adapter_en_i;
		if (clear_req_i) begin
			rdy_data_o <= 1'b0;
		end
	end

	// slow acceptance makes the sender hold each character
	always @(negedge mclk_i) begin
		if (tx_ready_o) begin
			tx_ready_o <= 1'b0;
			tx_wait <= 0;
		end else if (tx_valid_i) begin
			if (tx_wait >= tx_delay) begin
				tx_ready_o <= 1'b1;
				tx_q.push_back(tx_char_i);
			end
			tx_wait <= tx_wait + 1;
		end
	end

	// clear confirm after a short pause, withdrawn with the request
	always @(negedge mclk_i) begin
		if (!clear_req_i) begin
			dce_clear_o <= 1'b0;
			clr_wait <= 0;
		end else begin
			clr_wait <= clr_wait + 1;
			if (clr_wait == 3) begin
				dce_clear_o <= 1'b1;
			end
		end
	end

	// an idle receive line carries the inverse of the last character
	task automatic send_char(input logic [7:0] c);
		@(negedge mclk_i);
		rx_valid_o <= 1'b1;
		rx_char_o <= c;
		@(negedge mclk_i);
		rx_valid_o <= 1'b0;
		rx_char_o <= ~c;
	endtask : send_char

	task automatic go_data();
		@(negedge mclk_i);
		rdy_data_o <= 1'b1;
	endtask : go_data
endmodule : xcs_dce_model

// *** verif/tb.sv ***
// self-checking bench for the switched call-setup block
// assumes the network model is compiled before this file
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
	import xcs_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_valid_i = 1'b0;
	xcs_op_t req_op_i = OP_NONE;
	logic [2:0] req_rate_i = 3'h0;
	logic [5:0] req_sel_len_i = 6'h00;
	logic resume_i = 1'b0;
	logic sel_wr_i = 1'b0;
	logic [4:0] sel_addr_i = 5'h00;
	logic [7:0] sel_data_i = 8'h00;
	logic req_ready_o, stat_valid_o, cap_wr_o, adapter_rst_o, adapter_en_o;
	logic ctrl_c_o, clear_req_o, tx_valid_o, tx_ready_i, rx_valid_i;
	logic dce_ready_i, rdy_data_i, dce_clear_i, data_phase_o, frame_arm_o;
	logic [7:0] stat_code_o, cap_data_o, tx_char_o, rx_char_i;
	logic [4:0] cap_addr_o;
	logic [16:0] line_rate_o;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	int n_arm = 0;
	logic [7:0] stat_q[$];
	logic [12:0] cap_q[$];
	logic [16:0] rates[5] = '{17'h00960, 17'h012C0, 17'h02580, 17'h0BB80,
		17'h0FA00};

	// short counts keep the supervision timeouts within a brief run
	xcs_call_setup #(.SHORT_CYC(36'h000000028), .LONG_CYC(36'h0000000C8)) dut (
		.mclk_i, .rst_i, .req_valid_i, .req_op_i, .req_rate_i, .req_sel_len_i,
		.req_ready_o, .resume_i, .sel_wr_i, .sel_addr_i, .sel_data_i,
		.stat_valid_o, .stat_code_o, .cap_wr_o, .cap_addr_o, .cap_data_o,
		.adapter_rst_o, .adapter_en_o, .line_rate_o, .ctrl_c_o, .clear_req_o,
		.tx_valid_o, .tx_char_o, .tx_ready_i, .rx_valid_i, .rx_char_i,
		.dce_ready_i, .rdy_data_i, .dce_clear_i, .data_phase_o, .frame_arm_o);
	xcs_dce_model dce (.mclk_i, .adapter_en_i(adapter_en_o),
		.clear_req_i(clear_req_o), .tx_valid_i(tx_valid_o),
		.tx_char_i(tx_char_o), .dce_ready_o(dce_ready_i),
		.rdy_data_o(rdy_data_i), .dce_clear_o(dce_clear_i),
		.rx_valid_o(rx_valid_i), .rx_char_o(rx_char_i), .tx_ready_o(tx_ready_i));

	initial forever #2 mclk_i = ~mclk_i;

	// ************************************************************
	// monitors and shared tasks
	// ************************************************************
	always @(negedge mclk_i) begin
		if (stat_valid_o === 1'b1) stat_q.push_back(stat_code_o);
		if (cap_wr_o === 1'b1) cap_q.push_back({cap_addr_o, cap_data_o});
		if (frame_arm_o === 1'b1) n_arm++;
	end

	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// the request stands until the edge that samples ready high
	task automatic request(input xcs_op_t op, input logic [2:0] rate,
		input logic [5:0] len);
		@(negedge mclk_i);
		req_valid_i <= 1'b1;
		req_op_i <= op;
		req_rate_i <= rate;
		req_sel_len_i <= len;
		#1;
		repeat (50) if (req_ready_o !== 1'b1) @(negedge mclk_i);
		`CHK(req_ready_o, 1'b1)
		@(negedge mclk_i);
		req_valid_i <= 1'b0;
		req_op_i <= OP_NONE;
	endtask : request

	task automatic wait_stat(input logic [7:0] e);
		logic [7:0] code;
		repeat (400) if (stat_q.size() == 0) @(negedge mclk_i);
		code = (stat_q.size() > 0) ? stat_q.pop_front() : 8'hXX;
		`CHK(code, e)
	endtask : wait_stat

	task automatic halt(input logic [7:0] e);
		request(OP_HALT, 3'h0, 6'h00);
		`CHK(clear_req_o, 1'b1)
		`CHK(ctrl_c_o, 1'b0)
		wait_stat(e);
	endtask : halt

	task automatic wait_ctrl();
		repeat (40) if (ctrl_c_o !== 1'b1) @(negedge mclk_i);
		`CHK(ctrl_c_o, 1'b1)
	endtask : wait_ctrl

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		@(negedge mclk_i);
		`CHK(line_rate_o, 17'h00000)
		`CHK(adapter_en_o, 1'b0)
		req_op_i <= OP_HALT;
		@(negedge mclk_i);
		`CHK(req_ready_o, 1'b0)
		req_op_i <= OP_OPEN_OUT;
		@(negedge mclk_i);
		`CHK(req_ready_o, 1'b1)
		req_op_i <= OP_NONE;
		$display("test reset done");
	endtask : t_reset

	task automatic t_rates();
		for (int i = 5; i < 8; i++) begin
			request(OP_OPEN_OUT, 3'(i), 6'h00);
			wait_stat(ST_ERR_RATE);
		end
		for (int i = 0; i < 5; i++) begin
			request(OP_OPEN_OUT, 3'(i), 6'h00);
			`CHK(line_rate_o, rates[i])
			halt(ST_HALTED);
		end
		$display("test rates done");
	endtask : t_rates

	task automatic t_dial();
		int n;
		int arm0;
		for (int i = 0; i < 3; i++) begin
			@(negedge mclk_i);
			sel_wr_i <= 1'b1;
			sel_addr_i <= 5'(i);
			sel_data_i <= 8'h31 + 8'(i);
		end
		@(negedge mclk_i);
		sel_wr_i <= 1'b0;
		dce.tx_delay = 3;
		dce.tx_q.delete();
		cap_q.delete();
		request(OP_OPEN_OUT, 3'h2, 6'h03);
		n = 0;
		repeat (60) begin
			if (adapter_en_o === 1'b1) break;
			if (adapter_rst_o === 1'b1) n++;
			@(negedge mclk_i);
		end
		`CHK(n, 32'(ADP_RST_CYC))
		wait_ctrl();
		`CHK(dce.tx_q.size(), 0)
		req_op_i <= OP_OPEN_IN;
		#1;
		`CHK(req_ready_o, 1'b0)
		dce.send_char(CH_PLUS);
		req_op_i <= OP_NONE;
		repeat (80) if (dce.tx_q.size() < 5) @(negedge mclk_i);
		`CHK(dce.tx_q.size(), 5)
		foreach (dce.tx_q[i])
			`CHK(dce.tx_q[i], (i < 2) ? CH_SYNC : 8'h2F + 8'(i))
		dce.send_char(CH_ZERO);
		dce.send_char(8'h31);
		dce.send_char(CH_PLUS);
		wait_stat(ST_INFO);
		`CHK(cap_q.size(), 2)
		`CHK(cap_q[0], {5'h00, CH_ZERO})
		`CHK(cap_q[1], {5'h01, 8'h31})
		repeat (100) @(negedge mclk_i);
		`CHK(stat_q.size(), 0)
		arm0 = n_arm;
		dce.go_data();
		wait_stat(ST_NORMAL);
		repeat (3) @(negedge mclk_i);
		`CHK(data_phase_o, 1'b1)
		`CHK(n_arm - arm0, 1)
		halt(ST_HALTED);
		$display("test dialled call done");
	endtask : t_dial

	task automatic t_direct();
		dce.tx_delay = 0;
		dce.tx_q.delete();
		request(OP_OPEN_OUT, 3'h4, 6'h00);
		wait_ctrl();
		dce.send_char(CH_PLUS);
		repeat (10) @(negedge mclk_i);
		`CHK(dce.tx_q.size(), 0)
		repeat (55) @(negedge mclk_i);
		`CHK(stat_q.size(), 1)
		wait_stat(ST_ERR_TMO);
		$display("test direct call done");
	endtask : t_direct

	task automatic t_incoming();
		cap_q.delete();
		request(OP_OPEN_IN, 3'h2, 6'h00);
		repeat (30) @(negedge mclk_i);
		`CHK(ctrl_c_o, 1'b0)
		dce.send_char(CH_BELL);
		wait_stat(ST_BELL);
		repeat (5) @(negedge mclk_i);
		`CHK(ctrl_c_o, 1'b0)
		resume_i <= 1'b1;
		repeat (3) @(negedge mclk_i);
		resume_i <= 1'b0;
		`CHK(ctrl_c_o, 1'b1)
		dce.send_char(8'h41);
		dce.send_char(8'h42);
		dce.send_char(CH_PLUS);
		wait_stat(ST_INFO);
		`CHK(cap_q[0], {5'h00, 8'h41})
		dce.go_data();
		wait_stat(ST_NORMAL);
		halt(ST_HALTED);
		$display("test incoming call done");
	endtask : t_incoming

	initial begin
		repeat (12) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_i <= 1'b0;
		t_reset();
		t_rates();
		t_dial();
		t_direct();
		t_incoming();
		report_and_stop();
	end
endmodule : tb
